// File: design/sagc_ctrl.sv
// Converter output and amplifier control with an APB register slave
// Functional notes
// - Four-bit gain code drives exponential amplifier gain
// - Unity feedback select bypasses gain, diagnostics
// - Offset code maps linearly between offset references
// - One ten-bit sample per converter period
// - Convert at converter edge, word follows it
// - Float control releases all sample outputs
// - Complement control inverts the whole word
// - Curve select picks gamma-like gamma_curve_select conversion
// - Bit zero least, bit nine most significant
// - Low reference gives 0, high gives 1023
// - Fast trim acts once when unity set
`timescale 1ns/1ps
module sagc_ctrl #(
  parameter int unsigned SAMPLE_DIV = sagc_pkg::SAMPLE_DIV
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Quantised converter input level, 0 at low reference
  input wire logic [9:0] adc_level,
  // Amplifier controls
  output logic [3:0] amp_gain_code,
  output logic amp_unity_fb,
  output logic [3:0] amp_offset_code,
  output logic offset_slow_strobe,
  output logic offset_fast_strobe,
  // Sample word, bit 0 is sample_bit_lsb and bit 9 is sample_bit_msb
  output logic [9:0] sample_word,
  output logic sample_oe,
  output logic sample_valid
);
  initial begin
    // The sample spacing checks need at least four clocks per sample
    if (SAMPLE_DIV < 4 || SAMPLE_DIV > 65535) begin
      $error("sagc_ctrl: SAMPLE_DIV out of range");
    end
  end

  logic [31:0] ctrl_ff;
  logic slow_trim_ff;
  logic fast_trim_ff;
  logic fast_arm_ff;
  logic [15:0] div_ff;
  logic conv_en;
  logic [9:0] curve_code;
  logic [9:0] conv_code;
  logic [9:0] nxt_word;
  logic [9:0] sample_word_ff;
  logic sample_valid_ff;
  logic [6:0] slow_cnt_ff;
  logic slow_fire;
  logic fast_fire;
  logic offset_slow_ff;
  logic offset_fast_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic wr_ctrl;
  logic wr_trim;
  logic setup;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == sagc_pkg::CTRL_OFS) || (a == sagc_pkg::TRIM_OFS) ||
               (a == sagc_pkg::STAT_OFS);
  endfunction : addr_hit

  // Bus decode: zero wait states, read data captured at setup
  assign setup = psel && !penable;
  assign wr_ctrl = psel && penable && pwrite && (paddr == sagc_pkg::CTRL_OFS);
  assign wr_trim = psel && penable && pwrite && (paddr == sagc_pkg::TRIM_OFS);
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      pslverr_ff <= !addr_hit(paddr);
      prdata_ff <= 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          sagc_pkg::CTRL_OFS: prdata_ff <= ctrl_ff;
          sagc_pkg::TRIM_OFS: begin
            prdata_ff[sagc_pkg::SLOW_BIT] <= slow_trim_ff;
            prdata_ff[sagc_pkg::FAST_BIT] <= fast_trim_ff;
          end
          sagc_pkg::STAT_OFS: begin
            prdata_ff[sagc_pkg::STAT_WORD_LSB +: sagc_pkg::WORD_W] <= sample_word_ff;
            prdata_ff[sagc_pkg::STAT_CNT_LSB +: sagc_pkg::CNT_W] <= slow_cnt_ff;
            prdata_ff[sagc_pkg::STAT_CONV_BIT] <= (slow_cnt_ff >= sagc_pkg::SLOW_CONVERGE);
          end
          default: prdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Settings take effect at once; the controller keeps changes to blanking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= sagc_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata & sagc_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_trim_ff <= 1'b0;
      fast_trim_ff <= 1'b0;
    end else if (wr_trim) begin
      slow_trim_ff <= pwdata[sagc_pkg::SLOW_BIT];
      fast_trim_ff <= pwdata[sagc_pkg::FAST_BIT];
    end
  end

  // Amplifier control pins straight from the control register
  assign amp_gain_code = ctrl_ff[sagc_pkg::GAIN_LSB +: sagc_pkg::GAIN_W];
  assign amp_unity_fb = ctrl_ff[sagc_pkg::UNITY_BIT];
  assign amp_offset_code = ctrl_ff[sagc_pkg::OFFS_LSB +: sagc_pkg::OFFS_W];

  // Slow trim acts on the 1 to 0 edge of its bit; the input must be settled
  assign slow_fire = wr_trim && slow_trim_ff && !pwdata[sagc_pkg::SLOW_BIT];
  // Fast trim fires once per assertion, only under unity feedback
  assign fast_fire = fast_trim_ff && amp_unity_fb && !fast_arm_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_arm_ff <= 1'b0;
      offset_fast_ff <= 1'b0;
    end else begin
      fast_arm_ff <= fast_trim_ff && amp_unity_fb;
      offset_fast_ff <= fast_fire;
    end
  end

  // Strobe count saturates; the flag shows the usual convergence point
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_slow_ff <= 1'b0;
      slow_cnt_ff <= 7'h00;
    end else begin
      offset_slow_ff <= slow_fire;
      if (wr_ctrl && pwdata[sagc_pkg::OFFS_LSB +: sagc_pkg::OFFS_W] != amp_offset_code) begin
        slow_cnt_ff <= 7'h00;
      end else if (slow_fire && slow_cnt_ff != 7'h7F) begin
        slow_cnt_ff <= slow_cnt_ff + 7'h01;
      end
    end
  end

  assign offset_slow_strobe = offset_slow_ff;
  assign offset_fast_strobe = offset_fast_ff;

  // Converter edge: one enable pulse per sample period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 16'h0000;
    end else if (div_ff == 16'(SAMPLE_DIV - 1)) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end
  assign conv_en = (div_ff == 16'h0000);

  sagc_gamma u_gamma (
    .lin_code(adc_level),
    .curve_code(curve_code)
  );

  // Linear path is the level itself, full scale 0..1023
  // Curve chosen in conversion, inversion last on the final word
  always_comb begin
    conv_code = ctrl_ff[sagc_pkg::GAMMA_BIT] ? curve_code : adc_level;
    nxt_word = ctrl_ff[sagc_pkg::COMPL_BIT] ? ~conv_code : conv_code;
  end

  // The word is held for the whole period, like a latched converter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_word_ff <= 10'h000;
      sample_valid_ff <= 1'b0;
    end else begin
      sample_valid_ff <= conv_en;
      if (conv_en) begin
        sample_word_ff <= nxt_word;
      end
    end
  end

  assign sample_word = sample_word_ff;
  assign sample_valid = sample_valid_ff;
  // Float releases every bit together; the board resolves the level
  assign sample_oe = !ctrl_ff[sagc_pkg::FLOAT_BIT];

  property p_valid_after_edge;
    @(posedge pclk) disable iff (!presetn) conv_en |=> sample_valid ##1 !sample_valid;
  endproperty
  a_valid_after_edge: assert property (p_valid_after_edge)
    else $error("sample_valid not a single pulse after converter edge");

  property p_period;
    @(posedge pclk) disable iff (!presetn) sample_valid |=> !sample_valid [*3];
  endproperty
  a_period: assert property (p_period)
    else $error("samples closer than one converter period");

  property p_word_follows;
    @(posedge pclk) disable iff (!presetn) conv_en |=> sample_word == $past(nxt_word);
  endproperty
  a_word_follows: assert property (p_word_follows)
    else $error("sample word not taken at converter edge");

  property p_float;
    @(posedge pclk) disable iff (!presetn) sample_oe != ctrl_ff[sagc_pkg::FLOAT_BIT];
  endproperty
  a_float: assert property (p_float)
    else $error("output enable disagrees with float control");

  property p_linear;
    @(posedge pclk) disable iff (!presetn)
      conv_en && !ctrl_ff[sagc_pkg::GAMMA_BIT] && !ctrl_ff[sagc_pkg::COMPL_BIT]
      |=> sample_word == $past(adc_level);
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear word differs from input level");

  property p_invert;
    @(posedge pclk) disable iff (!presetn)
      conv_en && !ctrl_ff[sagc_pkg::GAMMA_BIT] && ctrl_ff[sagc_pkg::COMPL_BIT]
      |=> sample_word == ~$past(adc_level);
  endproperty
  a_invert: assert property (p_invert)
    else $error("complemented word wrong");

  property p_gamma_ends;
    @(posedge pclk) disable iff (!presetn)
      conv_en && ctrl_ff[sagc_pkg::GAMMA_BIT] && !ctrl_ff[sagc_pkg::COMPL_BIT] &&
      (adc_level == 10'h3FF || adc_level == 10'h000)
      |=> sample_word == $past(adc_level);
  endproperty
  a_gamma_ends: assert property (p_gamma_ends)
    else $error("gamma curve end points wrong");

  property p_gamma_dark;
    @(posedge pclk) disable iff (!presetn)
      conv_en && ctrl_ff[sagc_pkg::GAMMA_BIT] && !ctrl_ff[sagc_pkg::COMPL_BIT] &&
      adc_level == 10'h040 |=> sample_word == 10'h073;
  endproperty
  a_gamma_dark: assert property (p_gamma_dark)
    else $error("gamma curve does not expand dark codes");

  property p_fast_once;
    @(posedge pclk) disable iff (!presetn)
      offset_fast_strobe |-> $past(fast_trim_ff) && $past(amp_unity_fb) ##1 !offset_fast_strobe;
  endproperty
  a_fast_once: assert property (p_fast_once)
    else $error("fast trim strobe without unity or longer than one cycle");

  property p_ctrl_pins;
    @(posedge pclk) disable iff (!presetn)
      wr_ctrl |=> amp_gain_code == $past(pwdata[3:0]) && amp_offset_code == $past(pwdata[11:8]);
  endproperty
  a_ctrl_pins: assert property (p_ctrl_pins)
    else $error("amplifier codes do not follow control write");

  c_gamma: cover property (@(posedge pclk) disable iff (!presetn)
    conv_en && ctrl_ff[sagc_pkg::GAMMA_BIT]);
  c_fast: cover property (@(posedge pclk) disable iff (!presetn) offset_fast_strobe);
  c_conv: cover property (@(posedge pclk) disable iff (!presetn)
    slow_cnt_ff == sagc_pkg::SLOW_CONVERGE);
  c_err: cover property (@(posedge pclk) disable iff (!presetn) penable && pslverr);
endmodule : sagc_ctrl

// File: design/sagc_pkg.sv
// Constants for the sensor converter output and amplifier control block
package sagc_pkg;
  // Bus and register map
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] TRIM_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  // CTRL fields
  localparam int unsigned GAIN_LSB = 0;
  localparam int unsigned UNITY_BIT = 4;
  localparam int unsigned OFFS_LSB = 8;
  localparam int unsigned FLOAT_BIT = 16;
  localparam int unsigned COMPL_BIT = 17;
  localparam int unsigned GAMMA_BIT = 18;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0007_0F1F;
  // TRIM fields
  localparam int unsigned SLOW_BIT = 0;
  localparam int unsigned FAST_BIT = 1;
  // STATUS fields
  localparam int unsigned STAT_WORD_LSB = 0;
  localparam int unsigned STAT_CNT_LSB = 16;
  localparam int unsigned STAT_CONV_BIT = 24;
  // Code widths
  localparam int unsigned GAIN_W = 4;
  localparam int unsigned OFFS_W = 4;
  localparam int unsigned WORD_W = 10;
  localparam int unsigned CNT_W = 7;
  // Slow trim converges after this many strobes
  localparam logic [6:0] SLOW_CONVERGE = 7'h64;
  // Timing: system clock and nominal sample rate
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned SAMPLE_HZ = 10_000_000;
  localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
  // Gamma curve knots every 64 linear codes, y = 1343.5 * (1 - exp(-x/713))
  localparam int unsigned SEG_W = 4;
  localparam int unsigned FRAC_W = 6;
  localparam logic [9:0] GAMMA_KNOT [0:16] = '{
    10'h000, 10'h073, 10'h0DD, 10'h13D, 10'h195, 10'h1E6, 10'h22F, 10'h273,
    10'h2B0, 10'h2E9, 10'h31C, 10'h34B, 10'h376, 10'h39D, 10'h3C1, 10'h3E2,
    10'h3FF};
endpackage : sagc_pkg

// File: design/sagc_gamma.sv
// Piecewise-linear gamma-like curve for the converter word
`timescale 1ns/1ps
module sagc_gamma (
  // Linear code in
  input wire logic [9:0] lin_code,
  // Curve code out
  output logic [9:0] curve_code
);
  logic [3:0] seg;
  logic [5:0] frac;
  logic [9:0] knot_lo;
  logic [9:0] knot_hi;
  logic [9:0] delta;
  logic [15:0] prod;

  function automatic logic [9:0] knot_at(input logic [4:0] idx);
    knot_at = sagc_pkg::GAMMA_KNOT[idx];
  endfunction : knot_at

  // Expands dark codes, compresses bright ones; monotonic by construction
  always_comb begin
    seg = lin_code[9:6];
    frac = lin_code[5:0];
    knot_lo = knot_at({1'b0, seg});
    knot_hi = knot_at(5'({1'b0, seg}) + 5'h01);
    delta = knot_hi - knot_lo;
    prod = 16'(delta) * 16'(frac);
    // Top code pinned to full scale; interpolation alone stops one code short
    curve_code = (&lin_code) ? '1 : knot_lo + 10'(prod[15:6]);
  end
endmodule : sagc_gamma

// File: tb/sagc_partner.sv
// Controller-side model: drives the converter level and captures samples
`timescale 1ns/1ps
module sagc_partner (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level wanted by the bench
  input wire logic [9:0] want_level,
  // Converter side
  output logic [9:0] adc_level = 10'h000,
  input wire logic [9:0] sample_word,
  input wire logic sample_valid,
  // Captured samples
  output logic [9:0] last_word = 10'h000,
  output int period = 0,
  output int n_samples = 0
);
  int cnt = 0;
  // Level moves only just after a sample, so no conversion sees a half-set input
  always @(posedge pclk) begin
    if (presetn !== 1'b1) begin
      cnt <= 0;
    end else if (sample_valid === 1'b1) begin
      adc_level <= want_level;
      last_word <= sample_word;
      period <= cnt;
      cnt <= 1;
      n_samples <= n_samples + 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : sagc_partner

// File: tb/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t %s", $time, m); end end
module testbench;
  localparam int unsigned DIV = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic [9:0] adc_level, last_word, sample_word;
  logic [9:0] want = 10'h000;
  logic [3:0] amp_gain_code, amp_offset_code;
  logic amp_unity_fb, offset_slow_strobe, offset_fast_strobe, sample_oe, sample_valid;
  int n_errors = 0, n_compared = 0, period, n_samples, n_fast = 0, n_slow = 0;

  sagc_ctrl #(.SAMPLE_DIV(DIV)) sagc_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .adc_level, .amp_gain_code,
    .amp_unity_fb, .amp_offset_code, .offset_slow_strobe, .offset_fast_strobe,
    .sample_word, .sample_oe, .sample_valid);
  sagc_partner sagc_partner_inst (.pclk, .presetn, .want_level(want), .adc_level,
    .sample_word, .sample_valid, .last_word, .period, .n_samples);

  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    if (offset_fast_strobe === 1'b1) n_fast++;
    if (offset_slow_strobe === 1'b1) n_slow++;
  end

  // Entered at a rising edge; leaves one idle cycle so strobes never meet
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [9:0] curve(input logic [9:0] x);
    logic [9:0] k0, k1;
    int d;
    // Top code is full scale on both conversion laws
    if (x == 10'h3FF) return 10'h3FF;
    k0 = sagc_pkg::GAMMA_KNOT[x[9:6]];
    k1 = sagc_pkg::GAMMA_KNOT[x[9:6] + 5'h01];
    d = ((int'(k1) - int'(k0)) * int'(x[5:0])) >> 6;
    return k0 + d[9:0];
  endfunction : curve

  task automatic t_reset();
    apb(1'b0, sagc_pkg::CTRL_OFS, 32'h0);
    `CHK(rd, sagc_pkg::CTRL_RST, "control reset value")
    `CHK(sample_oe, 1'b1, "outputs driven after reset")
    apb(1'b0, 12'h00C, 32'h0);
    `CHK({err, rd}, 33'h0_0000_0000 | 33'h1_0000_0000, "unmapped read")
    apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    `CHK(err, 1'b1, "unmapped write refused")
    $display("test reset done");
  endtask : t_reset

  task automatic t_codes();
    logic [31:0] v;
    for (int c = 0; c < 16; c++) begin
      v = {20'h0, 4'(15 - c), 4'h0, 4'(c)};
      apb(1'b1, sagc_pkg::CTRL_OFS, v);
      `CHK(amp_gain_code, 4'(c), "gain code pins")
      `CHK(amp_offset_code, 4'(15 - c), "offset code pins")
      apb(1'b0, sagc_pkg::CTRL_OFS, 32'h0);
      `CHK(rd, v, "control read back")
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_samples();
    logic [9:0] lv [4] = '{10'h000, 10'h3FF, 10'h064, 10'h040};
    logic [9:0] f;
    int s;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, sagc_pkg::CTRL_OFS, {13'h0, m[1], m[0], 17'h0});
      for (int i = 0; i < 4; i++) begin
        want <= lv[i];
        s = n_samples;
        while (n_samples < s + 3) @(posedge pclk);
        f = m[1] ? curve(lv[i]) : lv[i];
        `CHK(last_word, m[0] ? ~f : f, "sample word")
        `CHK(period, int'(DIV), "sample period")
        apb(1'b0, sagc_pkg::STAT_OFS, 32'h0);
        `CHK(rd[9:0], m[0] ? ~f : f, "status word")
      end
    end
    $display("test samples done");
  endtask : t_samples

  task automatic t_float();
    apb(1'b1, sagc_pkg::CTRL_OFS, 32'h0001_0000);
    `CHK(sample_oe, 1'b0, "outputs float")
    apb(1'b1, sagc_pkg::CTRL_OFS, 32'h0);
    `CHK(sample_oe, 1'b1, "outputs driven")
    $display("test float done");
  endtask : t_float

  task automatic t_fast();
    int s;
    s = n_fast;
    apb(1'b1, sagc_pkg::CTRL_OFS, 32'h0000_0010);
    `CHK(amp_unity_fb, 1'b1, "unity select pin")
    apb(1'b1, sagc_pkg::TRIM_OFS, 32'h2);
    repeat (8) @(posedge pclk);
    `CHK(n_fast, s + 1, "one fast trim strobe")
    apb(1'b1, sagc_pkg::TRIM_OFS, 32'h0);
    apb(1'b1, sagc_pkg::CTRL_OFS, 32'h0);
    `CHK(amp_unity_fb, 1'b0, "unity released")
    apb(1'b1, sagc_pkg::TRIM_OFS, 32'h2);
    repeat (8) @(posedge pclk);
    `CHK(n_fast, s + 1, "no fast trim without unity")
    apb(1'b1, sagc_pkg::TRIM_OFS, 32'h0);
    $display("test fast trim done");
  endtask : t_fast

  task automatic t_slow();
    int s;
    s = n_slow;
    // Count is at zero here: no slow strobe was sent before this test
    for (int i = 0; i < 100; i++) begin
      apb(1'b1, sagc_pkg::TRIM_OFS, 32'h1);
      apb(1'b1, sagc_pkg::TRIM_OFS, 32'h0);
      if (i == 98) begin
        apb(1'b0, sagc_pkg::STAT_OFS, 32'h0);
        `CHK({rd[24], rd[22:16]}, 8'h63, "not converged at 99")
      end
    end
    apb(1'b0, sagc_pkg::STAT_OFS, 32'h0);
    `CHK({rd[24], rd[22:16]}, 8'hE4, "converged at 100")
    `CHK(n_slow, s + 100, "slow strobe count")
    $display("test slow trim done");
  endtask : t_slow

  task automatic finish_test();
    $display("Counts: %0d compared, %0d mismatches", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_codes();
    t_samples();
    t_float();
    t_fast();
    t_slow();
    finish_test();
  end

  // Whole run is about 1000 cycles; a hang is cut well after that
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule : testbench
